// *** psp_pkg.sv ***
// constants, states and the byte parity function shared by the protection
// block; assumes 32-bit words split into four 8-bit bytes
package psp_pkg;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int DW = 32;
  localparam int NB = 4;
  localparam int BW = 8;
  localparam int CW = 39;
  localparam int HMAX = 38;
  localparam int SYNW = 6;
  localparam int MEM_AW = 16;
  localparam int IC_IDX_W = 4;
  localparam int IC_DEPTH = 16;
  localparam int IC_TAG_W = MEM_AW - IC_IDX_W;
  localparam int GAP_W = 16;

  // ----------------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------------
  localparam int SCRUB_GAP = 1024;
  localparam logic [GAP_W-1:0] GAP_ONE = 16'h0001;
  localparam logic [MEM_AW-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [MEM_AW-1:0] ADDR_STEP = 16'h0001;
  localparam logic [SYNW-1:0] SYN_ZERO = 6'h00;

  // memory controller states
  typedef enum logic [2:0] {
    MC_IDLE,
    MC_RD1,
    MC_RD2,
    MC_SC1,
    MC_SC2
  } psp_mc_state_t;

  // one even-parity bit per byte of a word
  function automatic logic [NB-1:0] psp_byte_par(input logic [DW-1:0] d);
    logic [NB-1:0] p;
    p = '0;
    for (int b = 0; b < NB; b++) begin
      p[b] = ^d[b*BW +: BW];
    end
    return p;
  endfunction
endpackage

// *** psp_secded.sv ***
// single-error-correct, double-error-detect coder for one 32-bit field
// purely combinational; the caller registers what it needs
`timescale 1ns/1ns
module psp_secded (
  // encoder side
  input wire logic [psp_pkg::DW-1:0] i_enc_data,
  output logic [psp_pkg::CW-1:0] o_enc_code,
  // decoder side
  input wire logic [psp_pkg::CW-1:0] i_dec_code,
  output logic [psp_pkg::DW-1:0] o_dec_data,
  output logic o_dec_single,
  output logic o_dec_double
);
  import psp_pkg::*;

  // ----------------------------------------------------------------------
  // encoder: hamming positions 1..38, overall parity in bit 0
  // ----------------------------------------------------------------------
  always_comb begin
    int j;
    logic [CW-1:0] c;
    j = 0;
    c = '0;
    for (int p = 1; p <= HMAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = i_enc_data[j];
        j++;
      end
    end
    for (int k = 0; k < SYNW; k++) begin
      for (int p = 1; p <= HMAX; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          c[1 << k] = c[1 << k] ^ c[p];
        end
      end
    end
    c[0] = ^c[CW-1:1];
    o_enc_code = c;
  end

  // ----------------------------------------------------------------------
  // decoder: syndrome, overall parity, flip and extract
  // ----------------------------------------------------------------------
  always_comb begin
    int j;
    logic [SYNW-1:0] syn;
    logic odd;
    logic [CW-1:0] fix;
    j = 0;
    syn = SYN_ZERO;
    fix = i_dec_code;
    o_dec_data = '0;
    for (int k = 0; k < SYNW; k++) begin
      for (int p = 1; p <= HMAX; p++) begin
        if (((p >> k) & 1) == 1) begin
          syn[k] = syn[k] ^ i_dec_code[p];
        end
      end
    end
    odd = ^i_dec_code;
    // odd weight with a syndrome in range is one flipped bit
    o_dec_single = odd && (int'(syn) <= HMAX);
    // even weight with a syndrome, or a syndrome out of range, is not fixable
    o_dec_double = (syn != SYN_ZERO) && !o_dec_single;
    if (o_dec_single && syn != SYN_ZERO) begin
      fix[syn] = ~fix[syn];
    end
    for (int p = 1; p <= HMAX; p++) begin
      if ((p & (p - 1)) != 0) begin
        o_dec_data[j] = fix[p];
        j++;
      end
    end
  end
endmodule

// *** psp_top.sv ***
// byte parity for results and operands, secded main memory control with
// background scrub, and a parity-protected direct-mapped instruction cache
// assumes a synchronous ram with one cycle read latency and a fill source
// that answers every fill request
// Functional notes
// - each result word gets one generated parity bit per byte
// - incoming operand byte parity is checked the clock after acceptance, mismatch flagged
// - parity travels and is checked one clock after its data word
// - carried parity is stored and forwarded unchanged, never regenerated
// - memory stores seven check bits per 32-bit field, 39 bits
// - memory reads correct single-bit errors and detect double-bit errors
// - scrubber reads every location and writes back the corrected codeword, except where the error is uncorrectable
// - cache detects single-bit errors in entry data or parity (tag is not covered) and recovers without software
// - cache keeps one parity bit per data byte with each entry
// - cache parity error reports miss and requests refill of the entry
`timescale 1ns/1ns
module psp_top #(
  parameter int SCRUB_GAP_CYC = psp_pkg::SCRUB_GAP
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // result generation
  input wire logic i_res_valid,
  input wire logic [psp_pkg::DW-1:0] i_res_data,
  output logic [psp_pkg::DW-1:0] o_res_data,
  output logic [psp_pkg::NB-1:0] o_res_par,
  // operand acceptance
  input wire logic i_opnd_valid,
  input wire logic [psp_pkg::DW-1:0] i_opnd_data,
  input wire logic [psp_pkg::NB-1:0] i_opnd_par,
  output logic [psp_pkg::DW-1:0] o_opnd_data,
  output logic [psp_pkg::NB-1:0] o_opnd_par,
  output logic o_opnd_perr,
  // memory requests
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [psp_pkg::MEM_AW-1:0] i_mem_addr,
  input wire logic [psp_pkg::DW-1:0] i_mem_wdata,
  output logic o_mem_ready,
  output logic o_rd_valid,
  output logic [psp_pkg::DW-1:0] o_rd_data,
  output logic o_rd_uerr,
  // error events
  output logic o_ce_pulse,
  output logic o_ue_pulse,
  output logic [psp_pkg::MEM_AW-1:0] o_err_addr,
  // ram port
  output logic o_ram_re,
  output logic o_ram_we,
  output logic [psp_pkg::MEM_AW-1:0] o_ram_addr,
  output logic [psp_pkg::CW-1:0] o_ram_wdata,
  input wire logic [psp_pkg::CW-1:0] i_ram_rdata,
  // instruction cache lookup
  input wire logic i_ic_req,
  input wire logic [psp_pkg::MEM_AW-1:0] i_ic_addr,
  output logic o_ic_valid,
  output logic o_ic_hit,
  output logic o_ic_perr,
  output logic [psp_pkg::DW-1:0] o_ic_data,
  // instruction cache refill
  output logic o_ic_fill_req,
  output logic [psp_pkg::MEM_AW-1:0] o_ic_fill_addr,
  input wire logic i_ic_fill_valid,
  input wire logic [psp_pkg::MEM_AW-1:0] i_ic_fill_addr,
  input wire logic [psp_pkg::DW-1:0] i_ic_fill_data
);
  import psp_pkg::*;

  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(SCRUB_GAP_CYC);

  // ----------------------------------------------------------------------
  // result and operand parity
  // ----------------------------------------------------------------------
  logic [DW-1:0] res_data_q, res_data_d;
  logic [NB-1:0] res_par_q, res_par_d;
  logic [DW-1:0] opnd_data_q, opnd_data_d;
  logic [NB-1:0] opnd_par_q, opnd_par_d;
  logic opnd_vld_q, opnd_vld_d, opnd_perr_q, opnd_perr_d;

  // data goes out one clock ahead of the parity that covers it
  always_comb begin
    res_data_d = i_res_valid ? i_res_data : res_data_q;
    res_par_d = psp_byte_par(res_data_q);
    opnd_data_d = i_opnd_valid ? i_opnd_data : opnd_data_q;
    opnd_vld_d = i_opnd_valid;
    opnd_par_d = i_opnd_par;
    // parity arrives the clock after its word and is checked then
    opnd_perr_d = opnd_vld_q &&
                  (psp_byte_par(opnd_data_q) != i_opnd_par);
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      res_data_q <= '0;
      res_par_q <= '0;
      opnd_data_q <= '0;
      opnd_par_q <= '0;
      opnd_vld_q <= 1'b0;
      opnd_perr_q <= 1'b0;
    end else begin
      res_data_q <= res_data_d;
      res_par_q <= res_par_d;
      opnd_data_q <= opnd_data_d;
      opnd_par_q <= opnd_par_d;
      opnd_vld_q <= opnd_vld_d;
      opnd_perr_q <= opnd_perr_d;
    end
  end

  assign o_res_data = res_data_q;
  assign o_res_par = res_par_q;
  assign o_opnd_data = opnd_data_q;
  assign o_opnd_par = opnd_par_q;
  assign o_opnd_perr = opnd_perr_q;

  a_res_par_lag: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_res_valid |-> ##2 (o_res_par == psp_byte_par($past(i_res_data, 2))))
    else $error("result parity not two clocks behind data");
  a_opnd_check: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_opnd_valid ##1 (psp_byte_par($past(i_opnd_data)) != i_opnd_par)
    |=> o_opnd_perr)
    else $error("operand parity mismatch not flagged");
  a_opnd_par_kept: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 (o_opnd_par == $past(i_opnd_par)))
    else $error("forwarded operand parity altered");

  // ----------------------------------------------------------------------
  // memory controller with scrub
  // ----------------------------------------------------------------------
  psp_mc_state_t st_q, st_d;
  logic ram_re_q, ram_re_d, ram_we_q, ram_we_d;
  logic [MEM_AW-1:0] ram_addr_q, ram_addr_d, scrub_addr_q, scrub_addr_d;
  logic [CW-1:0] ram_wdata_q, ram_wdata_d, enc_code;
  logic [DW-1:0] enc_data, dec_data, rd_data_q, rd_data_d;
  logic dec_single, dec_double;
  logic rd_vld_q, rd_vld_d, rd_uerr_q, rd_uerr_d;
  logic ce_q, ce_d, ue_q, ue_d;
  logic [MEM_AW-1:0] err_addr_q, err_addr_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  logic due_q, due_d;

  psp_secded u_secded (
    .i_enc_data(enc_data),
    .o_enc_code(enc_code),
    .i_dec_code(i_ram_rdata),
    .o_dec_data(dec_data),
    .o_dec_single(dec_single),
    .o_dec_double(dec_double)
  );

  assign o_mem_ready = (st_q == MC_IDLE);

  // host traffic first, scrub only when idle and no request pending
  always_comb begin
    st_d = st_q;
    ram_re_d = 1'b0;
    ram_we_d = 1'b0;
    ram_addr_d = ram_addr_q;
    ram_wdata_d = ram_wdata_q;
    scrub_addr_d = scrub_addr_q;
    rd_data_d = rd_data_q;
    rd_vld_d = 1'b0;
    rd_uerr_d = 1'b0;
    ce_d = 1'b0;
    ue_d = 1'b0;
    err_addr_d = err_addr_q;
    enc_data = (st_q == MC_SC2) ? dec_data : i_mem_wdata;
    gap_d = (gap_q == GAP_ONE) ? GAP_LOAD : gap_q - GAP_ONE;
    due_d = due_q || (gap_q == GAP_ONE);
    unique case (st_q)
      MC_IDLE: begin
        if (i_mem_req) begin
          ram_addr_d = i_mem_addr;
          if (i_mem_we) begin
            ram_we_d = 1'b1;
            ram_wdata_d = enc_code;
          end else begin
            ram_re_d = 1'b1;
            st_d = MC_RD1;
          end
        end else if (due_q) begin
          ram_addr_d = scrub_addr_q;
          ram_re_d = 1'b1;
          // a new due in this very cycle wins over the clear
          due_d = (gap_q == GAP_ONE);
          st_d = MC_SC1;
        end
      end
      MC_RD1: st_d = MC_RD2;
      MC_SC1: st_d = MC_SC2;
      MC_RD2, MC_SC2: begin
        // correct on the fly, never write a word it could not fix
        rd_data_d = (st_q == MC_RD2) ? dec_data : rd_data_q;
        rd_vld_d = (st_q == MC_RD2);
        rd_uerr_d = (st_q == MC_RD2) && dec_double;
        ce_d = dec_single;
        ue_d = dec_double;
        if (dec_single || dec_double) begin
          err_addr_d = ram_addr_q;
        end
        if (st_q == MC_SC2) begin
          ram_we_d = !dec_double;
          ram_wdata_d = enc_code;
          scrub_addr_d = scrub_addr_q + ADDR_STEP;
        end
        st_d = MC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_q <= MC_IDLE;
      ram_re_q <= 1'b0;
      ram_we_q <= 1'b0;
      ram_addr_q <= ADDR_ZERO;
      ram_wdata_q <= '0;
      scrub_addr_q <= ADDR_ZERO;
      rd_data_q <= '0;
      rd_vld_q <= 1'b0;
      rd_uerr_q <= 1'b0;
      ce_q <= 1'b0;
      ue_q <= 1'b0;
      err_addr_q <= ADDR_ZERO;
      gap_q <= GAP_LOAD;
      due_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ram_re_q <= ram_re_d;
      ram_we_q <= ram_we_d;
      ram_addr_q <= ram_addr_d;
      ram_wdata_q <= ram_wdata_d;
      scrub_addr_q <= scrub_addr_d;
      rd_data_q <= rd_data_d;
      rd_vld_q <= rd_vld_d;
      rd_uerr_q <= rd_uerr_d;
      ce_q <= ce_d;
      ue_q <= ue_d;
      err_addr_q <= err_addr_d;
      gap_q <= gap_d;
      due_q <= due_d;
    end
  end

  assign o_ram_re = ram_re_q;
  assign o_ram_we = ram_we_q;
  assign o_ram_addr = ram_addr_q;
  assign o_ram_wdata = ram_wdata_q;
  assign o_rd_valid = rd_vld_q;
  assign o_rd_data = rd_data_q;
  assign o_rd_uerr = rd_uerr_q;
  assign o_ce_pulse = ce_q;
  assign o_ue_pulse = ue_q;
  assign o_err_addr = err_addr_q;

  sequence s_rd_accept;
    o_mem_ready && i_mem_req && !i_mem_we;
  endsequence
  sequence s_scrub_read;
    (st_q == MC_SC2) && !dec_double;
  endsequence

  a_rd_latency: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_rd_accept |-> ##1 o_ram_re ##2 o_rd_valid)
    else $error("read answer not three clocks after accept");
  a_scrub_wback: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_scrub_read |=> (o_ram_we && o_ram_wdata == $past(enc_code)))
    else $error("scrub read not written back");
  a_scrub_yield: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_mem_ready && i_mem_req) |=> (st_q != MC_SC1))
    else $error("scrub started over a host request");
  a_scrub_step: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == MC_SC2) |=> (scrub_addr_q == $past(scrub_addr_q) + ADDR_STEP))
    else $error("scrub address did not advance by one");
  a_ue_event: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_ue_pulse |-> (!o_ce_pulse && o_err_addr == $past(ram_addr_q)))
    else $error("uncorrectable event without its address");

  // ----------------------------------------------------------------------
  // instruction cache with byte parity
  // ----------------------------------------------------------------------
  logic [IC_DEPTH-1:0] ic_vld_q, ic_vld_d;
  logic [IC_TAG_W-1:0] ic_tag [IC_DEPTH];
  logic [DW-1:0] ic_dat [IC_DEPTH];
  logic [NB-1:0] ic_par [IC_DEPTH];
  logic [IC_IDX_W-1:0] lk_idx, fill_idx;
  logic lk_match, lk_perr;
  logic ic_valid_q, ic_valid_d, ic_hit_q, ic_hit_d, ic_perr_q, ic_perr_d;
  logic ic_fill_q, ic_fill_d;
  logic [DW-1:0] ic_data_q, ic_data_d;
  logic [MEM_AW-1:0] ic_faddr_q, ic_faddr_d;

  assign lk_idx = i_ic_addr[IC_IDX_W-1:0];
  assign fill_idx = i_ic_fill_addr[IC_IDX_W-1:0];

  // a parity error is a miss: drop the entry and ask for a refill
  always_comb begin
    lk_match = ic_vld_q[lk_idx] &&
               (ic_tag[lk_idx] == i_ic_addr[MEM_AW-1:IC_IDX_W]);
    lk_perr = lk_match &&
              (psp_byte_par(ic_dat[lk_idx]) != ic_par[lk_idx]);
    ic_valid_d = i_ic_req;
    ic_hit_d = i_ic_req && lk_match && !lk_perr;
    ic_perr_d = i_ic_req && lk_perr;
    ic_fill_d = i_ic_req && !(lk_match && !lk_perr);
    ic_data_d = i_ic_req ? ic_dat[lk_idx] : ic_data_q;
    ic_faddr_d = i_ic_req ? i_ic_addr : ic_faddr_q;
    ic_vld_d = ic_vld_q;
    if (i_ic_req && lk_perr) begin
      ic_vld_d[lk_idx] = 1'b0;
    end
    // a fill in the same cycle wins over the invalidate
    if (i_ic_fill_valid) begin
      ic_vld_d[fill_idx] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ic_vld_q <= '0;
      ic_valid_q <= 1'b0;
      ic_hit_q <= 1'b0;
      ic_perr_q <= 1'b0;
      ic_fill_q <= 1'b0;
      ic_data_q <= '0;
      ic_faddr_q <= ADDR_ZERO;
    end else begin
      ic_vld_q <= ic_vld_d;
      ic_valid_q <= ic_valid_d;
      ic_hit_q <= ic_hit_d;
      ic_perr_q <= ic_perr_d;
      ic_fill_q <= ic_fill_d;
      ic_data_q <= ic_data_d;
      ic_faddr_q <= ic_faddr_d;
    end
  end

  // entry storage, guarded by the valid bits so no reset is needed; a plain
  // always lets a test flip stored bits to model a soft error
  always @(posedge i_clk_sys) begin
    if (i_ic_fill_valid) begin
      ic_tag[fill_idx] <= i_ic_fill_addr[MEM_AW-1:IC_IDX_W];
      ic_dat[fill_idx] <= i_ic_fill_data;
      ic_par[fill_idx] <= psp_byte_par(i_ic_fill_data);
    end
  end

  assign o_ic_valid = ic_valid_q;
  assign o_ic_hit = ic_hit_q;
  assign o_ic_perr = ic_perr_q;
  assign o_ic_data = ic_data_q;
  assign o_ic_fill_req = ic_fill_q;
  assign o_ic_fill_addr = ic_faddr_q;

  a_ic_perr_miss: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_ic_perr |-> (!o_ic_hit && o_ic_fill_req))
    else $error("cache parity error not turned into refill");
  a_ic_par_store: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ic_fill_valid |=> (ic_par[$past(fill_idx)] ==
                         psp_byte_par(ic_dat[$past(fill_idx)])))
    else $error("cache entry stored without byte parity");
  a_ic_drop_bad: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ic_req && lk_perr && !i_ic_fill_valid) |=> !ic_vld_q[$past(lk_idx)])
    else $error("bad cache entry kept valid");
endmodule

// *** psp_ram_model.sv ***
// behavioural main memory array standing behind the protection block
// assumes one cycle read latency: data of the address sampled with the
// read strobe is shown for one cycle after that edge
`timescale 1ns/1ns
module psp_ram_model (
  // clock
  input wire logic i_clk_sys,
  // ram port from the block
  input wire logic i_re,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [38:0] i_wdata,
  output logic [38:0] o_rdata
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // full array, cleared so unwritten words read as the all-zero codeword
  logic [38:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 39'h00_0000_0000;
    end
  end

  function automatic logic [38:0] peek(input logic [15:0] a);
    peek = mem[a];
  endfunction

  // flips stored bits to model a soft error in the array
  task automatic corrupt(input logic [15:0] a, input logic [38:0] m);
    mem[a] = peek(a) ^ m;
  endtask

  // ----------------------------------------------------------------------
  // port
  // ----------------------------------------------------------------------
  // read data lasts one cycle, otherwise the bus shows changing junk
  initial o_rdata = 39'h00_0000_0000;
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= peek(i_addr);
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// *** psp_top_tb.sv ***
// self-checking bench for the parity and secded protection block
// assumes the block's package and the memory array model are compiled first
`timescale 1ns/1ns
module psp_top_tb;
  import psp_pkg::*;
  // ----------------------------------------------------------------------
  // bench state
  // ----------------------------------------------------------------------
  `define CHK(n, e, g) begin checks_done++; \
    if ((g) !== (e)) begin miscompares++; \
      $display("mismatch %s exp %h got %h", n, e, g); end end
  int miscompares = 0;
  int checks_done = 0;
  int ce_seen = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic res_v = 1'b0;
  logic [DW-1:0] res_d = 32'h0000_0000;
  logic op_v = 1'b0;
  logic [DW-1:0] op_d = 32'h0000_0000;
  logic [NB-1:0] op_p = 4'h0;
  logic m_req = 1'b0;
  logic m_we = 1'b0;
  logic [MEM_AW-1:0] m_a = 16'h0000;
  logic [DW-1:0] m_wd = 32'h0000_0000;
  logic ic_req = 1'b0;
  logic [MEM_AW-1:0] ic_a = 16'h0000;
  logic fv = 1'b0;
  logic [MEM_AW-1:0] fa = 16'h0000;
  logic [DW-1:0] fd = 32'h0000_0000;
  logic [DW-1:0] o_res_d, o_op_d, o_rd_d, o_ic_d;
  logic [NB-1:0] o_res_p, o_op_p;
  logic o_perr, o_rdy, o_rdv, o_ue_rd, o_ce, o_ue, o_re, o_we;
  logic o_icv, o_hit, o_icp, o_frq;
  logic [MEM_AW-1:0] o_ea, o_ra, o_fa;
  logic [CW-1:0] o_wd, ram_rd;

  // ----------------------------------------------------------------------
  // design and memory array
  // ----------------------------------------------------------------------
  psp_top #(.SCRUB_GAP_CYC(8)) u_psp_top (
    .i_clk_sys(clk), .i_reset(rst),
    .i_res_valid(res_v), .i_res_data(res_d),
    .o_res_data(o_res_d), .o_res_par(o_res_p),
    .i_opnd_valid(op_v), .i_opnd_data(op_d), .i_opnd_par(op_p),
    .o_opnd_data(o_op_d), .o_opnd_par(o_op_p), .o_opnd_perr(o_perr),
    .i_mem_req(m_req), .i_mem_we(m_we), .i_mem_addr(m_a),
    .i_mem_wdata(m_wd), .o_mem_ready(o_rdy), .o_rd_valid(o_rdv),
    .o_rd_data(o_rd_d), .o_rd_uerr(o_ue_rd),
    .o_ce_pulse(o_ce), .o_ue_pulse(o_ue), .o_err_addr(o_ea),
    .o_ram_re(o_re), .o_ram_we(o_we), .o_ram_addr(o_ra),
    .o_ram_wdata(o_wd), .i_ram_rdata(ram_rd),
    .i_ic_req(ic_req), .i_ic_addr(ic_a), .o_ic_valid(o_icv),
    .o_ic_hit(o_hit), .o_ic_perr(o_icp), .o_ic_data(o_ic_d),
    .o_ic_fill_req(o_frq), .o_ic_fill_addr(o_fa),
    .i_ic_fill_valid(fv), .i_ic_fill_addr(fa), .i_ic_fill_data(fd)
  );
  psp_ram_model u_psp_ram_model (
    .i_clk_sys(clk), .i_re(o_re), .i_we(o_we), .i_addr(o_ra),
    .i_wdata(o_wd), .o_rdata(ram_rd)
  );

  // clock and corrected-event count
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (o_ce === 1'b1) ce_seen++;
  end

  // ----------------------------------------------------------------------
  // reference codes
  // ----------------------------------------------------------------------
  function automatic logic [3:0] bp(input logic [31:0] d);
    bp = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // data at non power of two places, checks at powers, overall at bit 0
  function automatic logic [38:0] enc(input logic [31:0] d);
    logic [38:0] c;
    int j;
    c = 39'h00_0000_0000;
    j = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 3; p <= 38; p++) begin
        if (p[k] && (p & (p - 1)) != 0) c[1 << k] ^= c[p];
      end
    end
    c[0] = ^c[38:1];
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // back to back results: data one clock, parity a clock later
  task automatic t_result(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    res_v <= 1'b1;
    res_d <= a;
    @(posedge clk);
    res_d <= b;
    @(negedge clk);
    `CHK("res_data", a, o_res_d);
    @(posedge clk);
    res_v <= 1'b0;
    res_d <= ~b;
    @(negedge clk);
    `CHK("res_data", b, o_res_d);
    `CHK("res_par", bp(a), o_res_p);
    @(negedge clk);
    `CHK("res_par", bp(b), o_res_p);
  endtask

  // a clean operand then a corrupt one, parity following its data
  task automatic t_operand(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    op_v <= 1'b1;
    op_d <= a;
    @(posedge clk);
    op_d <= b;
    op_p <= bp(a);
    @(posedge clk);
    op_v <= 1'b0;
    op_p <= bp(b) ^ 4'h2;
    @(negedge clk);
    `CHK("opnd_perr", 1'b0, o_perr);
    `CHK("opnd_par", bp(a), o_op_p);
    `CHK("opnd_data", b, o_op_d);
    @(posedge clk);
    op_p <= 4'h0;
    @(negedge clk);
    `CHK("opnd_perr", 1'b1, o_perr);
    `CHK("opnd_par", bp(b) ^ 4'h2, o_op_p);
  endtask

  // holds the request until ready, released at the taking edge
  task automatic mem_go(input logic we, input logic [15:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    m_req <= 1'b1;
    m_we <= we;
    m_a <= a;
    m_wd <= d;
    do begin
      @(negedge clk);
      n++;
    end while (o_rdy !== 1'b1 && n < 60);
    `CHK("mem_ready", 1'b1, o_rdy);
    @(posedge clk);
    m_req <= 1'b0;
    m_wd <= ~d;
  endtask

  task automatic mem_wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    mem_go(1'b1, a, d);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (o_we !== 1'b1 && n < 4);
    `CHK("ram_we", 1'b1, o_we);
    `CHK("ram_addr", a, o_ra);
    `CHK("ram_wdata", enc(d), o_wd);
  endtask

  task automatic mem_rd(input logic [15:0] a, input logic [31:0] d,
                        input logic ce, input logic ue);
    int n;
    mem_go(1'b0, a, 32'h0000_0000);
    @(negedge clk);
    `CHK("ram_re", 1'b1, o_re);
    `CHK("ram_rd_addr", a, o_ra);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (o_rdv !== 1'b1 && n < 8);
    `CHK("rd_valid", 1'b1, o_rdv);
    if (!ue) `CHK("rd_data", d, o_rd_d);
    `CHK("rd_uerr", ue, o_ue_rd);
    `CHK("ce_pulse", ce, o_ce);
    `CHK("ue_pulse", ue, o_ue);
    if (ce || ue) `CHK("err_addr", a, o_ea);
  endtask

  // one lookup, answer seen one clock later
  task automatic ic_look(input logic [15:0] a, input logic hit,
                         input logic pe, input logic [31:0] d);
    @(posedge clk);
    ic_req <= 1'b1;
    ic_a <= a;
    @(posedge clk);
    ic_req <= 1'b0;
    @(negedge clk);
    `CHK("ic_valid", 1'b1, o_icv);
    `CHK("ic_hit", hit, o_hit);
    `CHK("ic_perr", pe, o_icp);
    `CHK("ic_fill_req", ~hit, o_frq);
    if (hit) begin
      `CHK("ic_data", d, o_ic_d);
    end else begin
      `CHK("ic_fill_addr", a, o_fa);
    end
  endtask

  task automatic ic_fill(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    fv <= 1'b1;
    fa <= a;
    fd <= d;
    @(posedge clk);
    fv <= 1'b0;
    fd <= ~d;
  endtask

  // scrub finds a flipped bit at word 3 and rewrites it clean
  task automatic t_scrub();
    u_psp_ram_model.corrupt(16'h0003, 39'h00_0000_0020);
    repeat (100) @(posedge clk);
    `CHK("scrub_ce_count", 1, ce_seen);
    `CHK("scrub_err_addr", 16'h0003, o_ea);
    `CHK("scrub_word", 39'h0, u_psp_ram_model.peek(16'h0003));
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    `CHK("reset_ready", 1'b1, o_rdy);
    rst <= 1'b0;
    t_scrub();
    t_result(32'h80ff_0107, 32'h0f01_7e03);
    t_operand(32'h1234_5678, 32'ha5c3_0f81);
    mem_wr(16'h0100, 32'hdead_beef);
    mem_wr(16'h0101, 32'h0000_0001);
    mem_rd(16'h0100, 32'hdead_beef, 1'b0, 1'b0);
    u_psp_ram_model.corrupt(16'h0100, 39'h00_0000_0080);
    mem_rd(16'h0100, 32'hdead_beef, 1'b1, 1'b0);
    u_psp_ram_model.corrupt(16'h0101, 39'h00_0000_0001);
    mem_rd(16'h0101, 32'h0000_0001, 1'b1, 1'b0);
    u_psp_ram_model.corrupt(16'h0100, 39'h00_0010_0000);
    mem_rd(16'h0100, 32'hdead_beef, 1'b0, 1'b1);
    ic_look(16'h0125, 1'b0, 1'b0, 32'h0);
    ic_fill(16'h0125, 32'h0bad_f00d);
    ic_look(16'h0125, 1'b1, 1'b0, 32'h0bad_f00d);
    ic_look(16'h0135, 1'b0, 1'b0, 32'h0);
    // one stored bit flips: miss with refill request, entry dropped
    u_psp_top.ic_dat[5] = 32'h0bad_f00c;
    ic_look(16'h0125, 1'b0, 1'b1, 32'h0);
    ic_look(16'h0125, 1'b0, 1'b0, 32'h0);
    ic_fill(16'h0125, 32'h0bad_f00d);
    ic_look(16'h0125, 1'b1, 1'b0, 32'h0bad_f00d);
    print_verdict();
  end

  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
endmodule
